// file: hw/sew_bus_if.sv
// two-wire bus between the eeprom end and the master end
`timescale 1ns/100ps
interface sew_bus_if;
    logic scl_mst_o;
    logic scl_mst_oe;
    logic sda_mst_o;
    logic sda_mst_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    wire  scl;
    wire  sda;

    // open-drain wired-and, released lines read high
    assign scl = ~(scl_mst_oe & ~scl_mst_o);
    assign sda = ~((sda_mst_oe & ~sda_mst_o) | (sda_dev_oe & ~sda_dev_o));

    modport dev (
        input  scl,
        input  sda,
        output sda_dev_o,
        output sda_dev_oe
    );

    modport mst (
        input  scl,
        input  sda,
        output scl_mst_o,
        output scl_mst_oe,
        output sda_mst_o,
        output sda_mst_oe
    );
endinterface

// file: hw/sew_eeprom.sv
// two-wire eeprom end: address decode, page write, timed programming
`timescale 1ns/100ps
module sew_eeprom
    import sew_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYC
)
(
    sew_bus_if.dev             bus,
    input  logic               ref_clk,
    input  logic               arst_n,
    input  logic               addr_select_hi_pin,
    input  logic               addr_select_lo_pin,
    input  logic               write_protect_pin,
    input  logic [WADDR_W-1:0] rd_addr,
    output logic [7:0]         rd_data,
    output logic               prog_busy
);
    // nonvolatile array, one byte per word address
    logic [7:0]            mem [0:ARRAY_BYTES-1];
    logic [7:0]            page_buf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] wr_mask;
    logic [WADDR_W-1:0]    waddr;
    logic [4:0]            pin_s1;
    logic [4:0]            pin_s2;
    logic                  scl_d;
    logic                  sda_d;
    sew_dev_state_t        state;
    sew_dev_state_t        pend;
    sew_dev_state_t        next_phase;
    logic                  give_ack;
    logic [3:0]            bit_cnt;
    logic                  ack_ph;
    logic [7:0]            shreg;
    logic [PROG_CNT_W-1:0] prog_timer;

    // synchronised pins, only the second flop is read
    wire scl_s    = pin_s2[4];
    wire sda_s    = pin_s2[3];
    wire wp_s     = pin_s2[2];
    wire sel_hi_s = pin_s2[1];
    wire sel_lo_s = pin_s2[0];

    // bus events seen on the synchronised lines
    wire scl_rise  = scl_s & ~scl_d;
    wire scl_fall  = ~scl_s & scl_d;
    wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
    wire active    = state != SEW_D_IDLE;
    wire byte_done = scl_fall & (bit_cnt == BYTE_BITS) & ~ack_ph;
    wire ack_end   = scl_fall & ack_ph;
    wire accept    = byte_done & active & ~prog_busy & give_ack;

    // identity check of the address byte
    wire type_ok   = shreg[7:4] == DEV_TYPE;
    wire sel_ok    = (shreg[DA_SEL_HI] == sel_hi_s)
                   & (shreg[DA_SEL_LO] == sel_lo_s);
    wire id_match  = type_ok & sel_ok;

    // byte-wise loads into address and page buffer
    wire load_dev  = accept & (state == SEW_D_DEVADDR);
    wire load_word = accept & (state == SEW_D_WORD);
    wire load_data = accept & (state == SEW_D_DATA);

    // stop after at least one data byte; protect sampled right here
    wire prog_go   = bus_stop & ~prog_busy & (state == SEW_D_DATA)
                   & (|wr_mask) & ~wp_s;
    wire prog_done = prog_busy & (prog_timer == '0);

    // what the completed byte earns: ack or not, and the next phase
    always_comb begin
        give_ack   = 1'b0;
        next_phase = SEW_D_IDLE;
        case (state)
            SEW_D_DEVADDR: begin
                if (id_match) begin
                    give_ack = 1'b1;
                    // reads are outside this block: ack, then standby
                    next_phase = shreg[DA_DIR] ? SEW_D_IDLE
                                               : SEW_D_WORD;
                end
            end
            SEW_D_WORD: begin
                give_ack   = 1'b1;
                next_phase = SEW_D_DATA;
            end
            SEW_D_DATA: begin
                give_ack   = 1'b1;
                next_phase = SEW_D_DATA;
            end
            default: begin
                give_ack   = 1'b0;
                next_phase = SEW_D_IDLE;
            end
        endcase
    end

    // two flops on every pin, a third stage for edge finding
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1 <= 5'h18;
            pin_s2 <= 5'h18;
            scl_d  <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            pin_s1 <= {bus.scl, bus.sda, write_protect_pin,
                       addr_select_hi_pin, addr_select_lo_pin};
            pin_s2 <= pin_s1;
            scl_d  <= scl_s;
            sda_d  <= sda_s;
        end
    end

    // bit engine; programming freezes it in standby
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state          <= SEW_D_IDLE;
            pend           <= SEW_D_IDLE;
            bit_cnt        <= 4'h0;
            ack_ph         <= 1'b0;
            shreg          <= 8'h0;
            bus.sda_dev_o  <= 1'b0;
            bus.sda_dev_oe <= 1'b0;
        end else if (prog_busy || prog_go) begin
            // no start seen, so the address byte is never acked
            state          <= SEW_D_IDLE;
            ack_ph         <= 1'b0;
            bus.sda_dev_oe <= 1'b0;
        end else if (bus_start) begin
            state          <= SEW_D_DEVADDR;
            bit_cnt        <= 4'h0;
            ack_ph         <= 1'b0;
            bus.sda_dev_oe <= 1'b0;
        end else if (bus_stop) begin
            // protected write ends here, ready at once
            state          <= SEW_D_IDLE;
            ack_ph         <= 1'b0;
            bus.sda_dev_oe <= 1'b0;
        end else if (active) begin
            if (scl_rise && !ack_ph && bit_cnt != BYTE_BITS) begin
                shreg   <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (byte_done) begin
                // pull low through the whole ninth high phase
                ack_ph         <= 1'b1;
                bus.sda_dev_oe <= give_ack;
                pend           <= give_ack ? next_phase : SEW_D_IDLE;
            end
            if (ack_end) begin
                ack_ph         <= 1'b0;
                bus.sda_dev_oe <= 1'b0;
                bit_cnt        <= 4'h0;
                state          <= pend;
            end
        end
    end

    // word address counter and written-byte mask
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            waddr   <= '0;
            wr_mask <= '0;
        end else begin
            if (load_dev) begin
                waddr[WADDR_W-1] <= shreg[DA_WORD_MSB];
                wr_mask          <= '0;
            end
            if (load_word) begin
                waddr[7:0] <= shreg;
            end
            if (load_data) begin
                // upper bits hold the page, so the offset wraps
                wr_mask[waddr[PAGE_OFF_W-1:0]] <= 1'b1;
                waddr[PAGE_OFF_W-1:0] <=
                    waddr[PAGE_OFF_W-1:0] + 4'h1;
            end
        end
    end

    // self-timed programming, length set by parameter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_busy  <= 1'b0;
            prog_timer <= '0;
        end else if (prog_go) begin
            prog_busy  <= 1'b1;
            prog_timer <= PROG_CNT_W'(PROG_CYCLES - 1);
        end else if (prog_done) begin
            prog_busy  <= 1'b0;
        end else if (prog_busy) begin
            prog_timer <= prog_timer - 1'b1;
        end
    end

    // page buffer and array; wrapped bytes overwrite earlier ones
    always_ff @(posedge ref_clk) begin
        if (load_data) begin
            page_buf[waddr[PAGE_OFF_W-1:0]] <= shreg;
        end
        if (prog_done) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (wr_mask[i]) begin
                    mem[{waddr[WADDR_W-1:PAGE_OFF_W],
                         PAGE_OFF_W'(i)}] <= page_buf[i];
                end
            end
        end
    end

    // side port to look at array contents
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 8'h0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// file: hw/sew_master.sv
// two-wire bus master with a small wishbone command port
`timescale 1ns/100ps
module sew_master
    import sew_pkg::*;
(
    sew_bus_if.mst      bus,
    input  logic        ref_clk,
    input  logic        arst_n,
    input  logic        wb_cyc,
    input  logic        wb_stb,
    input  logic        wb_we,
    input  logic [3:0]  wb_adr,
    input  logic [3:0]  wb_sel,
    input  logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic        wb_ack
);
    sew_mst_state_t           state;
    logic [1:0]               qtr;
    logic [SCL_DIV_W-1:0]     div;
    logic [3:0]               bit_n;
    logic [7:0]               tx;
    logic                     send_req;
    logic                     stop_req;
    logic                     nack;
    logic                     sda_s1;
    logic                     sda_s;
    sew_mst_state_t           next_state;

    // request decode; commands while busy are acked but dropped
    wire bus_req  = wb_cyc & wb_stb & ~wb_ack;
    wire busy     = state != SEW_M_IDLE;
    wire cmd_wr   = bus_req & wb_we & (wb_adr == REG_CMD) & (&wb_sel[1:0])
                    & ~busy;
    wire c_start  = wb_dat_w[CMD_START_BIT];
    wire c_stop   = wb_dat_w[CMD_STOP_BIT];
    wire c_send   = wb_dat_w[CMD_SEND_BIT];
    wire tick     = busy & (div == SCL_DIV_W'(SCL_QTR_CYC - 1));
    wire last_q   = tick & (qtr == 2'h3);
    wire ack_bit  = bit_n == BYTE_BITS;
    wire dbit_end = bit_n == (BYTE_BITS - 4'h1);
    wire [31:0] stat_word = (32'(busy) << STAT_BUSY_BIT)
                          | (32'(nack) << STAT_NACK_BIT);
    wire [31:0] rd_word = (wb_adr == REG_STAT) ? stat_word : 32'h0;

    // phase order after each quarter-period sequence
    always_comb begin
        next_state = SEW_M_IDLE;
        case (state)
            SEW_M_START: begin
                next_state = send_req ? SEW_M_BIT
                           : (stop_req ? SEW_M_STOP : SEW_M_IDLE);
            end
            SEW_M_BIT: begin
                if (!ack_bit) begin
                    next_state = SEW_M_BIT;
                end else if (stop_req) begin
                    next_state = SEW_M_STOP;
                end
            end
            default: next_state = SEW_M_IDLE;
        endcase
    end

    // wishbone slave: one wait state, every access acked
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack   <= 1'b0;
            wb_dat_r <= 32'h0;
        end else begin
            wb_ack   <= bus_req;
            wb_dat_r <= rd_word;
        end
    end

    // sda is a pin, so two flops before use
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_s1 <= 1'b1;
            sda_s  <= 1'b1;
        end else begin
            sda_s1 <= bus.sda;
            sda_s  <= sda_s1;
        end
    end

    // sequencer and clock divider
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= SEW_M_IDLE;
            qtr      <= 2'h0;
            div      <= '0;
            bit_n    <= 4'h0;
            send_req <= 1'b0;
            stop_req <= 1'b0;
        end else begin
            div <= (!busy || tick) ? '0 : div + 1'b1;
            if (cmd_wr) begin
                send_req <= c_send;
                stop_req <= c_stop;
                qtr      <= 2'h0;
                bit_n    <= 4'h0;
                state    <= c_start ? SEW_M_START
                          : (c_send ? SEW_M_BIT
                          : (c_stop ? SEW_M_STOP : SEW_M_IDLE));
            end else if (tick) begin
                qtr <= qtr + 2'h1;
                if (last_q) begin
                    state <= next_state;
                    if (state == SEW_M_BIT) begin
                        bit_n <= bit_n + 4'h1;
                    end
                end
            end
        end
    end

    // line drive per quarter; data moves only while scl is low
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus.scl_mst_o  <= 1'b0;
            bus.scl_mst_oe <= 1'b0;
            bus.sda_mst_o  <= 1'b0;
            bus.sda_mst_oe <= 1'b0;
            tx             <= 8'h0;
            nack           <= 1'b0;
        end else if (cmd_wr) begin
            tx <= wb_dat_w[7:0];
        end else if (tick) begin
            case (state)
                SEW_M_START: begin
                    case (qtr)
                        2'h0: bus.sda_mst_oe <= 1'b0;
                        2'h1: bus.scl_mst_oe <= 1'b0;
                        2'h2: bus.sda_mst_oe <= 1'b1;
                        default: bus.scl_mst_oe <= 1'b1;
                    endcase
                end
                SEW_M_BIT: begin
                    case (qtr)
                        2'h0: begin
                            bus.scl_mst_oe <= 1'b1;
                            // release for the ninth clock
                            bus.sda_mst_oe <= ~ack_bit & ~tx[7];
                        end
                        2'h1: bus.scl_mst_oe <= 1'b0;
                        2'h2: begin
                            if (ack_bit) begin
                                nack <= sda_s;
                            end else begin
                                tx <= {tx[6:0], 1'b0};
                            end
                        end
                        default: begin
                            bus.scl_mst_oe <= 1'b1;
                            // free sda with the eighth fall, before the ack
                            if (dbit_end) begin
                                bus.sda_mst_oe <= 1'b0;
                            end
                        end
                    endcase
                end
                SEW_M_STOP: begin
                    case (qtr)
                        2'h0: bus.sda_mst_oe <= 1'b1;
                        2'h1: bus.scl_mst_oe <= 1'b0;
                        2'h2: bus.sda_mst_oe <= 1'b0;
                        default: bus.sda_mst_oe <= 1'b0;
                    endcase
                end
                default: bus.sda_mst_oe <= bus.sda_mst_oe;
            endcase
        end
    end
endmodule

// file: hw/sew_pkg.sv
// shared constants and types for the serial eeprom write path
// Functional notes
// - array is 32 pages of 16 bytes
// - every access opens with address byte
// - upper nibble must equal 1010
// - bits 3,2 compare with select pins
// - bit 1 is word address msb
// - bit 0 picks read or write
// - match acks, mismatch naks and idles
// - word byte loads low eight bits
// - ack all bytes, stop starts programming
// - master ends write with a stop
// - bus ignored while programming runs
// - up to 16 bytes in one page
// - fifteen more bytes, each acknowledged
// - only low four address bits increment
// - master should not exceed page remainder
// - master polls with write address byte
// - nak address while busy, ack after
// - protect pin high blocks all writes
// - protect sampled at the ending stop
// - protected write acks, skips programming
// - start and stop while clock high
// - ack holds data low ninth clock
// - bytes travel msb first
package sew_pkg;
    // clocking and programming time
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned PROG_TIME_NS  = 5000000;
    localparam int unsigned PROG_CYC      = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned PROG_CNT_W    = 20;
    // array geometry
    localparam int unsigned PAGE_COUNT    = 32;
    localparam int unsigned PAGE_BYTES    = 16;
    localparam int unsigned ARRAY_BYTES   = PAGE_COUNT * PAGE_BYTES;
    localparam int unsigned WADDR_W       = 9;
    localparam int unsigned PAGE_OFF_W    = 4;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    // address byte layout
    localparam logic [3:0]  DEV_TYPE      = 4'ha;
    localparam int unsigned DA_SEL_HI     = 3;
    localparam int unsigned DA_SEL_LO     = 2;
    localparam int unsigned DA_WORD_MSB   = 1;
    localparam int unsigned DA_DIR        = 0;
    // master serial clock divider
    localparam int unsigned SCL_PERIOD_NS = 4000;
    localparam int unsigned SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int unsigned SCL_DIV_W     = 9;
    // master register map
    localparam logic [3:0]  REG_CMD       = 4'h0;
    localparam logic [3:0]  REG_STAT      = 4'h4;
    localparam int unsigned CMD_START_BIT = 8;
    localparam int unsigned CMD_STOP_BIT  = 9;
    localparam int unsigned CMD_SEND_BIT  = 10;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_NACK_BIT = 1;

    typedef enum logic [1:0] {
        SEW_D_IDLE,
        SEW_D_DEVADDR,
        SEW_D_WORD,
        SEW_D_DATA
    } sew_dev_state_t;

    typedef enum logic [1:0] {
        SEW_M_IDLE,
        SEW_M_START,
        SEW_M_BIT,
        SEW_M_STOP
    } sew_mst_state_t;
endpackage

// file: verification/sew_link_sva.sv
// wire-level checks on the two-wire link between master and eeprom ends
`timescale 1ns/100ps
module sew_link_sva
    import sew_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_mst_oe,
    input wire logic sda_mst_oe,
    input wire logic sda_dev_oe
);
    localparam int ACK_MIN = 4 * SCL_QTR_CYC - 8;
    localparam int ACK_MAX = 4 * SCL_QTR_CYC + 8;
    localparam int HI_MIN  = 2 * SCL_QTR_CYC - 2;

    logic [15:0] ack_len;
    logic [15:0] hi_len;
    wire         hi_sat = (hi_len == 16'hffff);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // ack width and scl high time; high count saturates over long idle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_len <= 16'h0000;
            hi_len  <= 16'h0000;
        end else begin
            ack_len <= sda_dev_oe ? ack_len + 16'h0001 : 16'h0000;
            hi_len  <= scl_mst_oe ? 16'h0000
                     : (hi_sat ? hi_len : hi_len + 16'h0001);
        end
    end

    AST_DEV_ONLY_ON_RELEASE: assert property (
        sda_dev_oe |-> !sda_mst_oe)
        else $error("eeprom pulls sda while master still drives it");
    AST_DEV_EDGE_SCL_LOW: assert property (
        $changed(sda_dev_oe) |-> !scl)
        else $error("eeprom changed sda while scl high");
    AST_ACK_ONE_CLOCK: assert property (
        $fell(sda_dev_oe) |-> (ack_len >= ACK_MIN && ack_len <= ACK_MAX))
        else $error("eeprom ack not held for one full clock");
    AST_ACK_BEFORE_HIGH: assert property (
        $rose(sda_dev_oe) |-> !scl [*8])
        else $error("eeprom ack not set up ahead of scl high");
    AST_SCL_HIGH_MIN: assert property (
        $rose(scl_mst_oe) |-> hi_len >= HI_MIN)
        else $error("scl high phase too short");
    AST_START_BY_MASTER: assert property (
        ($fell(sda) && scl && $past(scl)) |-> sda_mst_oe)
        else $error("start not made by master");
    AST_START_THEN_CLOCK: assert property (
        ($fell(sda) && scl && $past(scl)) |-> scl [*8] ##[1:400] !scl)
        else $error("no clock low after start");
    AST_STOP_HOLDS: assert property (
        ($rose(sda) && scl && $past(scl)) |-> scl [*8])
        else $error("scl dropped right after stop");
endmodule

// file: verification/tb_top.sv
// self-checking bench: master and eeprom joined on one two-wire link
`timescale 1ns/100ps
module tb_top
    import sew_pkg::*;
;
    localparam int PROG_T = 14000;

    logic        ref_clk  = 1'b0;
    logic        arst_n   = 1'b0;
    logic        wb_cyc   = 1'b0;
    logic        wb_stb   = 1'b0;
    logic        wb_we    = 1'b0;
    logic [3:0]  wb_adr   = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic        sel_hi   = 1'b0;
    logic        sel_lo   = 1'b0;
    logic        wp       = 1'b0;
    logic [8:0]  rd_addr  = 9'h000;
    logic [7:0]  rd_data;
    logic        prog_busy;
    int          fail_count   = 0;
    int          total_checks = 0;
    int          busy_cyc     = 0;
    logic [7:0]  mdl [0:511];

    sew_bus_if bus_if();

    sew_master i_sew_master (.bus(bus_if), .ref_clk(ref_clk),
        .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(4'hf), .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

    sew_eeprom #(.PROG_CYCLES(PROG_T)) i_sew_eeprom (.bus(bus_if),
        .ref_clk(ref_clk), .arst_n(arst_n), .addr_select_hi_pin(sel_hi),
        .addr_select_lo_pin(sel_lo), .write_protect_pin(wp),
        .rd_addr(rd_addr), .rd_data(rd_data), .prog_busy(prog_busy));

    sew_link_sva u_link_chk (.ref_clk(ref_clk), .arst_n(arst_n),
        .scl(bus_if.scl), .sda(bus_if.sda), .scl_mst_oe(bus_if.scl_mst_oe),
        .sda_mst_oe(bus_if.sda_mst_oe), .sda_dev_oe(bus_if.sda_dev_oe));

    always #4 ref_clk = ~ref_clk;

    // programming length, counted independently of the design
    always @(posedge ref_clk) begin
        if (prog_busy === 1'b1) busy_cyc <= busy_cyc + 1;
    end

    task automatic close_out();
        if (fail_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask

    // classic single cycle; waits on ack with a bound, never a fixed count
    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= a;
        wb_dat_w <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk("wb ack timeout", 1, 0);
            close_out();
        end
        // data taken and request dropped at the edge that shows ack
        r = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    // one byte on the link, then poll status until the engine is idle
    task automatic send_byte(input logic [7:0] b, input logic st,
                             input logic sp, output logic nk);
        logic [31:0] r;
        int          n;
        wb(1'b1, REG_CMD, {21'h0, 1'b1, sp, st, b}, r);
        n = 0;
        do begin
            wb(1'b0, REG_STAT, 32'h0, r);
            n++;
        end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 8000);
        if (n >= 8000) begin
            chk("link timeout", 1, 0);
            close_out();
        end
        nk = r[STAT_NACK_BIT];
    endtask

    // address byte built from the pins; a miss flips the low select bit
    function automatic logic [7:0] dev_byte(input logic [8:0] a,
                                            input logic hit);
        return {DEV_TYPE, sel_hi, sel_lo ^ ~hit, a[8], 1'b0};
    endfunction

    // page write of n bytes; the model wraps inside the page
    task automatic page_wr(input logic [8:0] a, input int n);
        logic       nk;
        logic [7:0] d;
        logic [3:0] off;
        send_byte(dev_byte(a, 1'b1), 1'b1, 1'b0, nk);
        chk("address ack", 0, nk);
        send_byte(a[7:0], 1'b0, 1'b0, nk);
        chk("word ack", 0, nk);
        for (int i = 0; i < n; i++) begin
            d   = 8'($urandom);
            off = a[3:0] + 4'(i);
            send_byte(d, 1'b0, (i == n - 1), nk);
            chk("data ack", 0, nk);
            if (!wp) mdl[{a[8:4], off}] = d;
        end
    endtask

    task automatic rd_chk(input logic [8:0] a);
        @(posedge ref_clk);
        rd_addr <= a;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("array byte", {24'h0, mdl[a]}, {24'h0, rd_data});
    endtask

    logic [8:0] base;
    logic       nk;
    int         n;

    initial begin
        void'($urandom(32'ha54ea8bc));
        base   = {5'($urandom), 4'hf};
        repeat (2) @(posedge ref_clk);
        sel_hi <= 1'($urandom);
        sel_lo <= 1'($urandom);
        arst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        // wrong select bits: nacked and ignored
        send_byte(dev_byte(base, 1'b0), 1'b1, 1'b1, nk);
        chk("mismatch nack", 1, nk);
        // last offset of a page, second byte wraps to offset zero
        page_wr(base, 2);
        // protect raised after the stop must not cancel programming
        wp <= 1'b1;
        @(negedge ref_clk);
        chk("busy during program", 1, prog_busy);
        send_byte(dev_byte(base, 1'b1), 1'b1, 1'b1, nk);
        chk("poll while busy", 1, nk);
        n = 0;
        while (prog_busy !== 1'b0 && n < 20000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 20000) begin
            chk("program timeout", 1, 0);
            close_out();
        end
        chk("program length", PROG_T, busy_cyc);
        rd_chk(base);
        rd_chk({base[8:4], 4'h0});
        // protected write: acked, no programming, array unchanged
        page_wr(base, 1);
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("no program when protected", 0, prog_busy);
        chk("busy count unchanged", PROG_T, busy_cyc);
        @(posedge ref_clk);
        wp <= 1'b0;
        rd_chk(base);
        close_out();
    end
endmodule
